// file: hw/irp_pkg.sv
package irp_pkg;

	// Direct host locations.
	localparam logic [2:0] DIR_WDATA_LO = 3'h0;
	localparam logic [2:0] DIR_WDATA_HI = 3'h1;
	localparam logic [2:0] DIR_WADDR = 3'h2;
	localparam logic [2:0] DIR_RADDR = 3'h3;
	localparam logic [2:0] DIR_SEQ_CH0 = 3'h4;

	// Indirect address fields.
	localparam int CHAN_SEL_LSB = 12;
	localparam int IO_SEL_LSB = 8;
	localparam int SEL_W = 4;
	localparam int OFS_W = 8;
	localparam int MEM_AW = 5;
	localparam int NCHAN = 4;

	// Global locations.
	localparam logic [7:0] GLB_OUT_ROUTE = 8'h00;
	localparam logic [7:0] GLB_RNG_MAP = 8'h01;
	localparam logic [7:0] GLB_TEST_DATA = 8'h02;
	localparam logic [7:0] GLB_TEST_STROBE = 8'h03;
	localparam logic [7:0] GLB_SYNC_STROBE = 8'h04;
	localparam logic [7:0] GLB_SYNC_FEEDBACK = 8'h05;
	localparam logic [7:0] GLB_SOFT_RESET = 8'h06;

	// I/O control section offsets.
	localparam logic [7:0] IO_INPUT_FORMAT = 8'h00;
	localparam logic [7:0] IO_ROUTE_SLOT01 = 8'h01;
	localparam logic [7:0] IO_ROUTE_SLOT67 = 8'h04;
	localparam logic [7:0] IO_RNG_SYNC_CTRL = 8'h05;
	localparam logic [7:0] IO_SERIAL_CTRL = 8'h06;
	localparam logic [7:0] IO_SD1_SLOTS = 8'h07;
	localparam logic [7:0] IO_SD2_SLOTS = 8'h08;
	localparam logic [7:0] IO_DC_BLOCK = 8'h09;
	localparam logic [7:0] IO_SEQ_ORDER = 8'h0A;
	localparam logic [7:0] IO_RNG_CTRL = 8'h10;

	// Channel saturation register offset; a write clears the latched status.
	localparam logic [11:0] CH_SAT_OFS = 12'h01F;

	// Reset values.
	localparam logic [31:0] REG32_RST = 32'h0000_0000;
	localparam logic [15:0] REG16_RST = 16'h0000;

	// Host pins as sampled.
	typedef struct packed {
		logic ce_n;
		logic wr_n;
		logic rd_n;
		logic [2:0] addr;
		logic [15:0] data;
	} irp_pins_t;

	// Internal write strobe bundle.
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [11:0] ofs;
		logic [31:0] data;
	} irp_strobe_t;

endpackage : irp_pkg

// file: hw/irp_sec_mem.sv
`timescale 1ns/1ps
module irp_sec_mem #(
	parameter int NSEC = 4,
	parameter int AW = 5,
	parameter int DW = 32
) (
	// Clock.
	input wire logic clk,
	// Write side, one enable per section.
	input wire logic [NSEC-1:0] wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read side, one-hot section select.
	input wire logic [NSEC-1:0] rd_sel,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] bank_q [NSEC];
	logic [DW-1:0] rd_next;

	genvar g;
	generate
		for (g = 0; g < NSEC; g++) begin : g_bank
			logic [DW-1:0] mem [2**AW];
			always_ff @(posedge clk) begin
				if (wr_en[g]) begin
					mem[wr_addr] <= wr_data;
				end
			end
			assign bank_q[g] = mem[rd_addr];
		end
	endgenerate

	// An illegal multi-bit read select ORs the banks; the host must avoid it.
	always_comb begin
		rd_next = '0;
		for (int i = 0; i < NSEC; i++) begin
			if (rd_sel[i]) begin
				rd_next = rd_next | bank_q[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= rd_next;
	end

endmodule : irp_sec_mem

// file: hw/irp_port.sv
`timescale 1ns/1ps
// Behaviour
// (R1) Write to location 0 loads holding bits 15:0, location 1 bits 31:16.
// (R2) Write to location 2 stores indirect address and strobes holding data out.
// (R3) Write to location 3 sets the same address, selects reads, no strobe.
// (R4) Read of location 0 gives target bits 15:0, location 1 bits 31:16.
// (R5) Reads of locations 4 to 7 give next sequenced word of channels 0 to 3.
// (R6) Select nibbles of the indirect address pick the I/O section or channel.
// (R7) Global 0000h holds output controls and channel routing, readable back.
// (R8) Global 0001h holds range control to auxiliary bus mapping, readable back.
// (R9) Global 0002h holds test data and enables; 0003 strobes test data in.
// (R10) 0004 and 0005 pulse sync output, 0005 also feeds first sync input; 0006 resets.
// (R11) Globals 0003 to 0006 read as zero; 0007 to 00FF are reserved.
// (R12) Section offset 00 is input format; 01 to 04 route slot pairs in order.
// (R13) Section offset 06 is serial control; 07 and 08 are serial slot formats.
// (R14) Offsets 05, 09, 0A, 10 hold range sync, DC block, read order, range control.
// (R15) Host waits 4 clocks after a location 2 write before writing 0 or 1.
// (R16) Bits 11:8 pick sections D to A; writes broadcast, reads need one bit.
// (R17) Bits 15:12 pick channels 3 to 0; writes broadcast, reads need one bit.
// (R18) Channel saturation status bits stick until the saturation register is written.
// (R19) Writes to locations 4 to 7 are ignored.
module irp_port #(
	parameter logic [7:0] REVISION = 8'h5A // Arbitrary value.
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Host bus pins.
	input wire logic ce_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	// Channel side.
	input wire logic [irp_pkg::NCHAN-1:0] sat_event,
	input wire logic [irp_pkg::NCHAN*32-1:0] chan_rd_data,
	input wire logic [irp_pkg::NCHAN*16-1:0] seq_word,
	output logic [irp_pkg::NCHAN-1:0] seq_advance,
	output irp_pkg::irp_strobe_t chan_strobe,
	output logic chan_strobe_valid,
	// I/O section side.
	output irp_pkg::irp_strobe_t io_strobe,
	output logic io_strobe_valid,
	// Global controls and strobes.
	output logic [31:0] out_route_ctrl,
	output logic [31:0] range_map_ctrl,
	output logic [31:0] test_data_ctrl,
	output logic test_data_strobe,
	output logic sync_output_pulse,
	output logic first_sync_input,
	output logic soft_reset_pulse
);
	// Pin synchronisers: stage 1 feeds stage 2 only.
	irp_pkg::irp_pins_t pin_s1_reg, pin_s2_reg, pin_d_reg;
	irp_pkg::irp_pins_t pin_now;

	// Host side state.
	logic [31:0] hold_reg, hold_next;
	logic [15:0] iaddr_reg, iaddr_next;
	logic strobe_pend_reg, strobe_pend_next;
	logic [31:0] read_word_reg, read_word_next;
	logic [15:0] data_out_reg, data_out_next;
	logic data_oe_reg, data_oe_next;
	logic [irp_pkg::NCHAN-1:0] seq_adv_reg, seq_adv_next;

	// Target side state.
	logic [31:0] route_reg, route_next;
	logic [31:0] rmap_reg, rmap_next;
	logic [31:0] test_reg, test_next;
	logic [irp_pkg::NCHAN-1:0] sat_reg, sat_next;
	logic test_stb_reg, test_stb_next;
	logic sync_reg, sync_next;
	logic fsync_reg, fsync_next;
	logic srst_reg, srst_next;
	irp_pkg::irp_strobe_t cstb_reg, cstb_next, istb_reg, istb_next;
	logic cstb_v_reg, cstb_v_next, istb_v_reg, istb_v_next;

	// Decode helpers.
	logic wr_take, rd_done;
	logic [3:0] chan_sel, io_sel;
	logic [7:0] ofs8;
	logic is_global, is_io, is_chan, io_ofs_legal;
	logic [irp_pkg::NCHAN-1:0] mem_we;
	logic [31:0] mem_q;

	assign pin_now.ce_n = ce_n;
	assign pin_now.wr_n = wr_n;
	assign pin_now.rd_n = rd_n;
	assign pin_now.addr = addr;
	assign pin_now.data = data_in;

	always_ff @(posedge clk) begin
		pin_s1_reg <= pin_now;
		pin_s2_reg <= pin_s1_reg;
		pin_d_reg <= pin_s2_reg;
	end

	// The write is taken when wr_n returns high; address and data come from the cycle before,
	// so the host may change them together with the strobe edge.
	assign wr_take = pin_s2_reg.wr_n && !pin_d_reg.wr_n && !pin_d_reg.ce_n;
	assign rd_done = pin_s2_reg.rd_n && !pin_d_reg.rd_n && !pin_d_reg.ce_n;

	assign chan_sel = iaddr_reg[irp_pkg::CHAN_SEL_LSB +: irp_pkg::SEL_W];
	assign io_sel = iaddr_reg[irp_pkg::IO_SEL_LSB +: irp_pkg::SEL_W];
	assign ofs8 = iaddr_reg[irp_pkg::OFS_W-1:0];
	assign is_chan = |chan_sel; // [R6] [R17]
	assign is_io = !is_chan && (|io_sel); // [R6] [R16]
	assign is_global = !is_chan && !(|io_sel);
	// Only the documented section offsets are stored; the reserved ones are dropped. [R14]
	assign io_ofs_legal = (ofs8 <= irp_pkg::IO_SEQ_ORDER) || (ofs8 == irp_pkg::IO_RNG_CTRL);
	// A broadcast section write lands in every selected bank in the same cycle.
	assign mem_we = (strobe_pend_reg && is_io && io_ofs_legal) ? io_sel : '0; // [R16]

	irp_sec_mem #(
		.NSEC(irp_pkg::NCHAN),
		.AW(irp_pkg::MEM_AW),
		.DW(32)
	) u_sec_mem (
		.clk(clk),
		.wr_en(mem_we),
		.wr_addr(ofs8[irp_pkg::MEM_AW-1:0]),
		.wr_data(hold_reg),
		.rd_sel(io_sel),
		.rd_addr(ofs8[irp_pkg::MEM_AW-1:0]),
		.rd_data(mem_q)
	); // [R12] [R13] [R14]

	// Host side next state.
	always_comb begin
		hold_next = hold_reg;
		iaddr_next = iaddr_reg;
		strobe_pend_next = 1'b0;
		seq_adv_next = '0;
		if (wr_take) begin
			unique case (pin_d_reg.addr)
				irp_pkg::DIR_WDATA_LO: hold_next[15:0] = pin_d_reg.data; // [R1]
				irp_pkg::DIR_WDATA_HI: hold_next[31:16] = pin_d_reg.data; // [R1]
				irp_pkg::DIR_WADDR: begin
					iaddr_next = pin_d_reg.data; // [R2]
					strobe_pend_next = 1'b1; // [R2]
				end
				irp_pkg::DIR_RADDR: iaddr_next = pin_d_reg.data; // [R3]
				default: ; // Locations 4 to 7 take no write. [R19]
			endcase
		end
		if (rd_done && pin_d_reg.addr[2]) begin
			seq_adv_next[pin_d_reg.addr[1:0]] = 1'b1; // [R5]
		end
	end

	// Read source for the indirect read locations.
	always_comb begin
		read_word_next = '0;
		if (is_chan) begin
			for (int i = 0; i < irp_pkg::NCHAN; i++) begin
				if (chan_sel[i]) begin
					read_word_next = read_word_next | chan_rd_data[i*32 +: 32]; // [R17]
				end
			end
		end else if (is_io) begin
			// Reserved offsets are never written, so the memory would show unknown data there.
			read_word_next = io_ofs_legal ? mem_q : '0; // [R6] [R14]
		end else if (iaddr_reg[15:8] == 8'h00) begin
			unique case (ofs8)
				irp_pkg::GLB_OUT_ROUTE: read_word_next = route_reg; // [R7]
				irp_pkg::GLB_RNG_MAP: read_word_next = rmap_reg; // [R8]
				irp_pkg::GLB_TEST_DATA: read_word_next = test_reg; // [R9]
				default: read_word_next = '0; // Strobes and reserved read as zero. [R11]
			endcase
		end
	end

	// The output register is the third stage, so read data trail the strobe pins by three edges.
	always_comb begin
		data_oe_next = !pin_s2_reg.rd_n && !pin_s2_reg.ce_n;
		unique case (pin_s2_reg.addr)
			irp_pkg::DIR_WDATA_LO: data_out_next = read_word_reg[15:0]; // [R4]
			irp_pkg::DIR_WDATA_HI: data_out_next = read_word_reg[31:16]; // [R4]
			irp_pkg::DIR_WADDR: data_out_next = {REVISION, 1'b0, sat_reg[3], 1'b0, sat_reg[2],
				1'b0, sat_reg[1], 1'b0, sat_reg[0]}; // [R18]
			irp_pkg::DIR_RADDR: data_out_next = irp_pkg::REG16_RST;
			default: data_out_next = seq_word[pin_s2_reg.addr[1:0]*16 +: 16]; // [R5]
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hold_reg <= irp_pkg::REG32_RST;
			iaddr_reg <= irp_pkg::REG16_RST;
			strobe_pend_reg <= 1'b0;
			read_word_reg <= irp_pkg::REG32_RST;
			data_out_reg <= irp_pkg::REG16_RST;
			data_oe_reg <= 1'b0;
			seq_adv_reg <= '0;
		end else begin
			hold_reg <= hold_next;
			iaddr_reg <= iaddr_next;
			strobe_pend_reg <= strobe_pend_next;
			read_word_reg <= read_word_next;
			data_out_reg <= data_out_next;
			data_oe_reg <= data_oe_next;
			seq_adv_reg <= seq_adv_next;
		end
	end

	// Target side next state, driven by the internal write strobe.
	always_comb begin
		route_next = route_reg;
		rmap_next = rmap_reg;
		test_next = test_reg;
		test_stb_next = 1'b0;
		sync_next = 1'b0;
		fsync_next = 1'b0;
		srst_next = 1'b0;
		cstb_next = cstb_reg;
		istb_next = istb_reg;
		cstb_v_next = 1'b0;
		istb_v_next = 1'b0;
		sat_next = sat_reg;
		if (strobe_pend_reg && is_chan) begin
			cstb_next.sel = chan_sel; // [R17]
			cstb_next.ofs = iaddr_reg[11:0];
			cstb_next.data = hold_reg;
			cstb_v_next = 1'b1;
			if (iaddr_reg[11:0] == irp_pkg::CH_SAT_OFS) begin
				sat_next = sat_next & ~chan_sel; // [R18]
			end
		end
		if (strobe_pend_reg && is_io) begin
			istb_next.sel = io_sel; // [R16]
			istb_next.ofs = iaddr_reg[11:0];
			istb_next.data = hold_reg;
			istb_v_next = 1'b1;
		end
		if (strobe_pend_reg && is_global && iaddr_reg[15:8] == 8'h00) begin
			unique case (ofs8)
				irp_pkg::GLB_OUT_ROUTE: route_next = hold_reg; // [R7]
				irp_pkg::GLB_RNG_MAP: rmap_next = hold_reg; // [R8]
				irp_pkg::GLB_TEST_DATA: test_next = hold_reg; // [R9]
				irp_pkg::GLB_TEST_STROBE: test_stb_next = 1'b1; // [R9]
				irp_pkg::GLB_SYNC_STROBE: sync_next = 1'b1; // [R10]
				irp_pkg::GLB_SYNC_FEEDBACK: begin
					sync_next = 1'b1; // [R10]
					fsync_next = 1'b1; // [R10]
				end
				irp_pkg::GLB_SOFT_RESET: srst_next = 1'b1; // [R10]
				default: ; // Reserved globals are ignored. [R11]
			endcase
		end
		// A saturation event in the clearing cycle is kept.
		sat_next = sat_next | sat_event; // [R18]
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			route_reg <= irp_pkg::REG32_RST;
			rmap_reg <= irp_pkg::REG32_RST;
			test_reg <= irp_pkg::REG32_RST;
			sat_reg <= '0;
			test_stb_reg <= 1'b0;
			sync_reg <= 1'b0;
			fsync_reg <= 1'b0;
			srst_reg <= 1'b0;
			cstb_reg <= '0;
			istb_reg <= '0;
			cstb_v_reg <= 1'b0;
			istb_v_reg <= 1'b0;
		end else begin
			route_reg <= route_next;
			rmap_reg <= rmap_next;
			test_reg <= test_next;
			sat_reg <= sat_next;
			test_stb_reg <= test_stb_next;
			sync_reg <= sync_next;
			fsync_reg <= fsync_next;
			srst_reg <= srst_next;
			cstb_reg <= cstb_next;
			istb_reg <= istb_next;
			cstb_v_reg <= cstb_v_next;
			istb_v_reg <= istb_v_next;
		end
	end

	assign data_out = data_out_reg;
	assign data_oe = data_oe_reg;
	assign seq_advance = seq_adv_reg;
	assign chan_strobe = cstb_reg;
	assign chan_strobe_valid = cstb_v_reg;
	assign io_strobe = istb_reg;
	assign io_strobe_valid = istb_v_reg;
	assign out_route_ctrl = route_reg;
	assign range_map_ctrl = rmap_reg;
	assign test_data_ctrl = test_reg;
	assign test_data_strobe = test_stb_reg;
	assign sync_output_pulse = sync_reg;
	assign first_sync_input = fsync_reg;
	assign soft_reset_pulse = srst_reg;

endmodule : irp_port

// file: verif/irp_port_asserts.sv
`timescale 1ns/1ps
module irp_port_asserts (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Host pins.
	input wire logic ce_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [2:0] addr,
	input wire logic data_oe,
	// Results.
	input wire logic [irp_pkg::NCHAN-1:0] seq_advance,
	input wire irp_pkg::irp_strobe_t chan_strobe,
	input wire logic chan_strobe_valid,
	input wire logic io_strobe_valid,
	input wire logic [31:0] out_route_ctrl,
	input wire logic test_data_strobe,
	input wire logic sync_output_pulse,
	input wire logic first_sync_input,
	input wire logic soft_reset_pulse
);
	logic [7:0] age_reg, age_next;
	logic [2:0] wloc_reg, wloc_next, rloc_reg, rloc_next;
	logic fresh, pulse;
	always_comb begin
		age_next = (!reset_n || !wr_n) ? 8'h00 : age_reg + 8'(age_reg != 8'hFF);
		wloc_next = !reset_n ? 3'h0 : ((!wr_n && !ce_n) ? addr : wloc_reg);
		rloc_next = !reset_n ? 3'h0 : ((!rd_n && !ce_n) ? addr : rloc_reg);
	end
	always_ff @(posedge clk) begin
		age_reg <= age_next;
		wloc_reg <= wloc_next;
		rloc_reg <= rloc_next;
	end
	// The slack of the window covers the pin synchronisers, not any later strobe.
	assign fresh = wloc_reg == irp_pkg::DIR_WADDR && age_reg >= 8'h02 && age_reg <= 8'h0A;
	assign pulse = test_data_strobe | sync_output_pulse | soft_reset_pulse | chan_strobe_valid;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence rd_idle;
		rd_n [*5];
	endsequence
	sequence rd_busy;
		(!rd_n && !ce_n) [*5];
	endsequence
	AST_OE_ON: assert property (rd_busy |-> data_oe)
		else $error("Read data not driven.");
	AST_OE_OFF: assert property (rd_idle |-> !data_oe)
		else $error("Read data driven while idle.");
	AST_CHAN_STROBE: assert property (chan_strobe_valid |-> fresh && chan_strobe.sel != 4'h0)
		else $error("Channel strobe without address write.");
	AST_IO_STROBE: assert property (io_strobe_valid |-> fresh && !chan_strobe_valid)
		else $error("Section strobe without address write.");
	AST_GLB_PULSE: assert property ((test_data_strobe || sync_output_pulse || soft_reset_pulse) |-> fresh)
		else $error("Global pulse without address write.");
	AST_SYNC_FEEDBACK: assert property (first_sync_input |-> sync_output_pulse)
		else $error("Feedback without sync pulse.");
	AST_PULSE_ONE: assert property (pulse |=> !pulse)
		else $error("Pulse longer than one cycle.");
	AST_SEQ_ADVANCE: assert property (seq_advance != 4'h0 |-> rloc_reg[2] && seq_advance == 4'(4'h1 << rloc_reg[1:0]))
		else $error("Sequence advance on wrong channel.");
	AST_ROUTE_HOLD: assert property (!$stable(out_route_ctrl) |-> fresh)
		else $error("Routing control changed without write.");
endmodule : irp_port_asserts

// file: verif/irp_host_model.sv
`timescale 1ns/1ps
module irp_host_model (
	// Clock.
	input wire logic clk,
	// Host bus pins.
	output logic ce_n,
	output logic wr_n,
	output logic rd_n,
	output logic [2:0] addr,
	output logic [15:0] data_in,
	input wire logic [15:0] data_out
);
	initial begin
		{ce_n, wr_n, rd_n, addr, data_in} = {3'b111, 3'h0, 16'h0000};
	end
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		{ce_n, wr_n, addr, data_in} <= {2'b00, a, d};
		repeat (3) @(posedge clk);
		wr_n <= 1'b1;
		repeat (3) @(posedge clk);
		// A released bus must not keep showing the old word.
		{ce_n, data_in} <= {1'b1, ~d};
		repeat (6) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		{ce_n, rd_n, addr} <= {2'b00, a};
		repeat (6) @(posedge clk);
		d = data_out;
		{ce_n, rd_n} <= 2'b11;
		repeat (6) @(posedge clk);
	endtask : rd
endmodule : irp_host_model

// file: verif/irp_port_bench.sv
`timescale 1ns/1ps
module irp_port_bench;
	localparam logic [7:0] REV = 8'h5A; // Arbitrary value.
	localparam logic [7:0] OFS [11] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h10, 8'h0B};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ce_n, wr_n, rd_n, data_oe, chan_strobe_valid, io_strobe_valid;
	logic test_data_strobe, sync_output_pulse, first_sync_input, soft_reset_pulse;
	logic [2:0] addr;
	logic [15:0] data_in, data_out, w;
	logic [3:0] sat_event = 4'h0;
	logic [3:0] seq_advance;
	logic [31:0] out_route_ctrl, range_map_ctrl, test_data_ctrl, v;
	logic [7:0] cnt [10];
	logic [9:0] evt;
	irp_pkg::irp_strobe_t chan_strobe, io_strobe, cs_last, io_last;
	int err_count = 0;
	int compares = 0;
	always #4 clk = ~clk;
	irp_port #(.REVISION(REV)) dut (
		.clk(clk), .reset_n(reset_n), .ce_n(ce_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sat_event(sat_event),
		.chan_rd_data({32'hC3C3_0003, 32'hC2C2_0002, 32'hC1C1_0001, 32'hC0C0_0000}),
		.seq_word({16'h5E03, 16'h5E02, 16'h5E01, 16'h5E00}), .seq_advance(seq_advance),
		.chan_strobe(chan_strobe), .chan_strobe_valid(chan_strobe_valid),
		.io_strobe(io_strobe), .io_strobe_valid(io_strobe_valid),
		.out_route_ctrl(out_route_ctrl), .range_map_ctrl(range_map_ctrl),
		.test_data_ctrl(test_data_ctrl), .test_data_strobe(test_data_strobe),
		.sync_output_pulse(sync_output_pulse), .first_sync_input(first_sync_input),
		.soft_reset_pulse(soft_reset_pulse));
	irp_host_model host (.clk(clk), .ce_n(ce_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
		.data_in(data_in), .data_out(data_out));
	assign evt = {seq_advance, io_strobe_valid, chan_strobe_valid, soft_reset_pulse,
		first_sync_input, sync_output_pulse, test_data_strobe};
	always @(posedge clk) begin
		for (int k = 0; k < 10; k++) begin
			cnt[k] <= !reset_n ? 8'h00 : cnt[k] + 8'(evt[k] === 1'b1);
		end
		if (chan_strobe_valid === 1'b1) begin
			cs_last <= chan_strobe;
		end
		if (io_strobe_valid === 1'b1) begin
			io_last <= io_strobe;
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic iw(input logic [15:0] a, input logic [31:0] d);
		host.wr(3'h0, d[15:0]);
		host.wr(3'h1, d[31:16]);
		host.wr(3'h2, a);
	endtask : iw
	task automatic ir(input logic [15:0] a, output logic [31:0] d);
		logic [15:0] lo, hi;
		host.wr(3'h3, a);
		host.rd(3'h0, lo);
		host.rd(3'h1, hi);
		d = {hi, lo};
	endtask : ir
	task automatic close_out();
		$display("Compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("oe", 32'(data_oe), 32'h0);
		for (int i = 0; i < 3; i++) begin
			iw(16'(i), 32'h1234_5670 + 32'(i));
			ir(16'(i), v);
			check("glb", v, 32'h1234_5670 + 32'(i));
		end
		check("route", out_route_ctrl, 32'h1234_5670);
		check("map", range_map_ctrl, 32'h1234_5671);
		check("test", test_data_ctrl, 32'h1234_5672);
		for (int i = 3; i < 8; i++) begin
			iw(16'(i), 32'hFFFF_FFFF);
			ir(16'(i), v);
			check("strobe_rd", v, 32'h0);
		end
		check("tstrobe", 32'(cnt[0]), 32'h1);
		check("sync", 32'(cnt[1]), 32'h2);
		check("fback", 32'(cnt[2]), 32'h1);
		check("sreset", 32'(cnt[3]), 32'h1);
		check("route", out_route_ctrl, 32'h1234_5670);
		iw(16'h0001, 32'h0F0F_A5A5);
		host.wr(3'h3, 16'h0000);
		for (int i = 4; i < 8; i++) begin
			host.wr(3'(i), 16'hDEAD);
		end
		check("route", out_route_ctrl, 32'h1234_5670);
		host.wr(3'h2, 16'h0000);
		check("hold", out_route_ctrl, 32'h0F0F_A5A5);
		check("quiet", 32'(cnt[4]) + 32'(cnt[5]), 32'h0);
		iw(16'hA005, 32'h0BAD_CAFE);
		check("cstb", 32'({cs_last.sel, cs_last.ofs}), 32'hA005);
		check("cdata", cs_last.data, 32'h0BAD_CAFE);
		for (int j = 0; j < 4; j++) begin
			ir({4'h1 << j, 12'h005}, v);
			check("chan", v, 32'hC0C0_0000 + 32'h0101_0001 * 32'(j));
		end
		for (int k = 0; k < 11; k++) begin
			iw({8'h09, OFS[k]}, 32'h5000_0000 + 32'(OFS[k]));
			check("iosel", 32'(io_last.sel), 32'h9);
			check("iodat", io_last.data, 32'h5000_0000 + 32'(OFS[k]));
			for (int s = 0; s < 2; s++) begin
				ir({s == 0 ? 8'h01 : 8'h08, OFS[k]}, v);
				check("io", v, k == 10 ? 32'h0 : 32'h5000_0000 + 32'(OFS[k]));
			end
		end
		for (int j = 0; j < 4; j++) begin
			host.rd(3'(4 + j), w);
			check("seq", 32'(w), 32'h5E00 + 32'(j));
			check("adv", 32'(cnt[6 + j]), 32'h1);
		end
		@(posedge clk);
		sat_event <= 4'h4;
		@(posedge clk);
		sat_event <= 4'h0;
		for (int r = 0; r < 2; r++) begin
			host.rd(3'h2, w);
			check("sat", 32'(w), {16'h0, REV, 8'h10});
		end
		iw(16'h401F, 32'h0);
		host.rd(3'h2, w);
		check("satclr", 32'(w), {16'h0, REV, 8'h00});
		close_out();
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule : irp_port_bench
bind irp_port irp_port_asserts u_asserts (.clk(clk), .reset_n(reset_n), .ce_n(ce_n),
	.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .data_oe(data_oe), .seq_advance(seq_advance),
	.chan_strobe(chan_strobe), .chan_strobe_valid(chan_strobe_valid),
	.io_strobe_valid(io_strobe_valid), .out_route_ctrl(out_route_ctrl),
	.test_data_strobe(test_data_strobe), .sync_output_pulse(sync_output_pulse),
	.first_sync_input(first_sync_input), .soft_reset_pulse(soft_reset_pulse));
